// file: rtl/stepper_timing_pkg.sv
// Constants for the stepper velocity, power-down timing and microstep readback block.
// Assumes a single 25 MHz device clock and a host that writes registers by address.
package stepper_timing_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	// Register offsets
	localparam logic [6:0] ADDR_POWER_DOWN_DELAY = 7'h11;
	localparam logic [6:0] ADDR_STEP_INTERVAL = 7'h12;
	localparam logic [6:0] ADDR_QUIET_THRESHOLD = 7'h13;
	localparam logic [6:0] ADDR_INTERNAL_VELOCITY = 7'h22;
	localparam logic [6:0] ADDR_MICROSTEP_POSITION = 7'h6A;
	localparam logic [6:0] ADDR_PHASE_CURRENTS = 7'h6B;
	localparam logic [6:0] ADDR_CHOPPER_CONFIG = 7'h6C;
	localparam logic [6:0] ADDR_DRIVER_FLAGS = 7'h6F;
	localparam logic [6:0] ADDR_QUIET_PWM_CONFIG = 7'h70;
	localparam logic [6:0] ADDR_PWM_AMPLITUDE = 7'h71;
	localparam logic [6:0] ADDR_PWM_AUTOTUNE = 7'h72;
	// Reset values
	localparam logic [7:0] POWER_DOWN_DELAY_RESET = 8'h14;
	localparam logic [31:0] CHOPPER_CONFIG_RESET = 32'h10000053;
	localparam logic [31:0] QUIET_PWM_CONFIG_RESET = 32'hC10D0024;
	// Field positions
	localparam int MRES_LSB = 24;
	localparam logic [3:0] MRES_MAX = 4'h8;
	localparam int PHASE_B_LSB = 0;
	localparam int PHASE_A_LSB = 16;
	localparam int AUTO_OFFSET_LSB = 0;
	localparam int AUTO_GRADIENT_LSB = 16;
	// Limits and table geometry
	localparam logic [19:0] INTERVAL_MAX = 20'hFFFFF;
	localparam logic [23:0] VELOCITY_MAG_MAX = 24'h7FFFFF;
	localparam logic [23:0] VELOCITY_MOST_NEG = 24'h800000;
	localparam logic [9:0] PHASE_OFFSET = 10'h100;
	localparam logic [8:0] TABLE_PEAK = 9'h0FF;
	// Timing counts in clock cycles
	localparam int POWER_TICK_CYCLES = 262144;
	localparam int STANDSTILL_CYCLES = 1048576;
endpackage

// file: rtl/stepper_velocity_timing_regs.sv
// Velocity measurement, power-down timing, internal velocity generator and
// microstep readback. Assumes step/dir pins are asynchronous and that all
// other inputs, including the register port, come from logic on clk_sys.
//
// Summary of operation
// - After standstill wait programmed delay, units of 2^18 clocks, reset 20
// - Measure clocks between 1/256 microsteps, independent of microstep resolution
// - Step interval reads all ones on overflow or standstill
// - Threshold compare uses lower value threshold*15/16 minus one
// - Quiet mode while interval at or above threshold; zero disables
// - Zero internal velocity means motor follows step input only
// - Nonzero signed velocity moves motor, sign gives direction, magnitude limited
// - Generated steps appear on the index output
// - Sequencer registers only report state; writes to them ignored
// - Ten-bit microstep counter indexes phase A, wraps within wave
// - Phase B uses the table at position offset by 256
// - Current readback: phase B bits 8..0, phase A bits 24..16
// - Autotune readback: offset bits 7..0, gradient bits 23..16
// - After delay, lower current stepwise per programmable ticks; zero instant
`timescale 1ns/1ps
`default_nettype none
module stepper_velocity_timing_regs
	import stepper_timing_pkg::*;
#(
	parameter int TICK_CYCLES = stepper_timing_pkg::POWER_TICK_CYCLES,
	parameter int STILL_CYCLES = stepper_timing_pkg::STANDSTILL_CYCLES
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Step and direction pins
	input wire logic step_pin,
	input wire logic dir_pin,
	// Register port
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [stepper_timing_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [stepper_timing_pkg::DATA_W-1:0] reg_wdata,
	output logic [stepper_timing_pkg::DATA_W-1:0] reg_rdata,
	// Settings and results from neighbouring logic
	input wire logic quiet_mode_enable,
	input wire logic [4:0] run_current,
	input wire logic [4:0] hold_current,
	input wire logic [3:0] current_ramp_down_step_delay,
	input wire logic [7:0] auto_offset_value,
	input wire logic [7:0] auto_gradient_value,
	input wire logic [16:0] pwm_amplitude,
	input wire logic [31:0] driver_flags,
	// Motion and status outputs
	output logic index_pulse,
	output logic motor_dir,
	output logic standstill,
	output logic quiet_mode_active,
	output logic [4:0] current_scale,
	output logic [8:0] phase_a_current,
	output logic [8:0] phase_b_current
);
	import stepper_timing_pkg::*;

	typedef enum logic [1:0] {
		PD_RUN = 2'b00,
		PD_DELAY = 2'b01,
		PD_RAMP = 2'b10,
		PD_HOLD = 2'b11
	} power_state_t;

	// Half-wave parabola; close enough to a sine for readback and keeps no table
	function automatic logic [8:0] table_value(input logic [9:0] p);
		logic [17:0] h;
		logic [17:0] prod;
		logic [8:0] mag;
		h = {9'h000, p[8:0]};
		prod = h * (18'h00200 - h);
		mag = prod[16] ? TABLE_PEAK : {1'b0, prod[15:8]};
		return p[9] ? (9'h000 - mag) : mag;
	endfunction

	localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
	localparam logic [19:0] STILL_LAST = 20'(STILL_CYCLES - 1);

	logic step_s1_reg, step_s2_reg, step_s3_reg;
	logic dir_s1_reg, dir_s2_reg;
	logic [7:0] power_down_delay_reg;
	logic [19:0] quiet_threshold_reg;
	logic [23:0] internal_velocity_reg;
	logic [31:0] chopper_config_reg;
	logic [31:0] quiet_pwm_config_reg;
	logic [9:0] microstep_position_reg;
	logic [19:0] idle_count_reg;
	logic [19:0] step_interval_reg;
	logic [23:0] accum_reg;
	logic [19:0] prescale_reg;
	logic tick_reg;
	power_state_t power_state_reg;
	logic [7:0] delay_count_reg;
	logic [3:0] ramp_count_reg;
	logic [DATA_W-1:0] rdata_next;

	logic step_edge;
	logic velocity_mode;
	logic vel_negative;
	logic [23:0] vel_magnitude;
	logic [24:0] accum_sum;
	logic gen_step;
	logic advance;
	logic [3:0] mres_eff;
	logic [3:0] shift_eff;
	logic [9:0] step_increment;
	logic [19:0] lower_compare;
	logic [23:0] thr_times_15;

	assign step_edge = step_s2_reg & ~step_s3_reg;
	assign velocity_mode = (internal_velocity_reg != 24'h000000);
	assign vel_negative = internal_velocity_reg[23];
	always_comb
	begin
		if (internal_velocity_reg == VELOCITY_MOST_NEG)
			vel_magnitude = VELOCITY_MAG_MAX;
		else if (vel_negative)
			vel_magnitude = 24'h000000 - internal_velocity_reg;
		else
			vel_magnitude = internal_velocity_reg;
	end
	assign accum_sum = {1'b0, accum_reg} + {1'b0, vel_magnitude};
	assign gen_step = velocity_mode & accum_sum[24];
	assign advance = velocity_mode ? gen_step : step_edge;
	assign mres_eff = (chopper_config_reg[MRES_LSB+3:MRES_LSB] > MRES_MAX) ? MRES_MAX
		: chopper_config_reg[MRES_LSB+3:MRES_LSB];
	assign shift_eff = velocity_mode ? 4'h0 : mres_eff;
	assign step_increment = 10'(11'h001 << shift_eff);
	assign thr_times_15 = {4'h0, quiet_threshold_reg} * 24'h00000F;
	assign lower_compare = 20'(thr_times_15 >> 4) - 20'h00001;

	// Pin synchronisers
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			step_s1_reg <= 1'b0;
			step_s2_reg <= 1'b0;
			step_s3_reg <= 1'b0;
			dir_s1_reg <= 1'b0;
			dir_s2_reg <= 1'b0;
		end
		else
		begin
			step_s1_reg <= step_pin;
			step_s2_reg <= step_s1_reg;
			step_s3_reg <= step_s2_reg;
			dir_s1_reg <= dir_pin;
			dir_s2_reg <= dir_s1_reg;
		end
	end

	// Writable registers; writes to read-only addresses fall through
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			power_down_delay_reg <= POWER_DOWN_DELAY_RESET;
			quiet_threshold_reg <= 20'h00000;
			internal_velocity_reg <= 24'h000000;
			chopper_config_reg <= CHOPPER_CONFIG_RESET;
			quiet_pwm_config_reg <= QUIET_PWM_CONFIG_RESET;
		end
		else if (reg_write)
		begin
			case (reg_addr)
				ADDR_POWER_DOWN_DELAY: power_down_delay_reg <= reg_wdata[7:0];
				ADDR_QUIET_THRESHOLD: quiet_threshold_reg <= reg_wdata[19:0];
				ADDR_INTERNAL_VELOCITY: internal_velocity_reg <= reg_wdata[23:0];
				ADDR_CHOPPER_CONFIG: chopper_config_reg <= reg_wdata;
				ADDR_QUIET_PWM_CONFIG: quiet_pwm_config_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read mux
	always_comb
	begin
		case (reg_addr)
			ADDR_STEP_INTERVAL: rdata_next = {12'h000, step_interval_reg};
			ADDR_MICROSTEP_POSITION: rdata_next = {22'h000000, microstep_position_reg};
			ADDR_PHASE_CURRENTS: rdata_next = {7'h00, phase_a_current, 7'h00, phase_b_current};
			ADDR_CHOPPER_CONFIG: rdata_next = chopper_config_reg;
			ADDR_DRIVER_FLAGS: rdata_next = driver_flags;
			ADDR_QUIET_PWM_CONFIG: rdata_next = quiet_pwm_config_reg;
			ADDR_PWM_AMPLITUDE: rdata_next = {15'h0000, pwm_amplitude};
			ADDR_PWM_AUTOTUNE: rdata_next = {8'h00, auto_gradient_value, 8'h00, auto_offset_value};
			default: rdata_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			reg_rdata <= 32'h00000000;
		else if (reg_read)
			reg_rdata <= rdata_next;
	end

	// Velocity generator; the accumulator carry is one 1/256 microstep
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			accum_reg <= 24'h000000;
			index_pulse <= 1'b0;
		end
		else
		begin
			accum_reg <= velocity_mode ? accum_sum[23:0] : 24'h000000;
			index_pulse <= gen_step;
		end
	end

	// Microstep position and direction
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			microstep_position_reg <= 10'h000;
			motor_dir <= 1'b0;
		end
		else
		begin
			motor_dir <= velocity_mode ? vel_negative : dir_s2_reg;
			if (advance)
			begin
				if (velocity_mode ? vel_negative : dir_s2_reg)
					microstep_position_reg <= microstep_position_reg - step_increment;
				else
					microstep_position_reg <= microstep_position_reg + step_increment;
			end
		end
	end

	// Table readback
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			phase_a_current <= 9'h000;
			phase_b_current <= 9'h000;
		end
		else
		begin
			phase_a_current <= table_value(microstep_position_reg);
			phase_b_current <= table_value(microstep_position_reg + PHASE_OFFSET);
		end
	end

	// Interval measurement; the raw period is scaled down to 1/256 step units
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			idle_count_reg <= 20'h00000;
			step_interval_reg <= INTERVAL_MAX;
			standstill <= 1'b1;
		end
		else
		begin
			if (advance)
				idle_count_reg <= 20'h00000;
			else if (idle_count_reg != INTERVAL_MAX)
				idle_count_reg <= idle_count_reg + 20'h00001;
			standstill <= !advance && (idle_count_reg >= STILL_LAST);
			if (advance)
			begin
				// A step out of standstill has no meaningful period behind it
				if (standstill || idle_count_reg == INTERVAL_MAX)
					step_interval_reg <= INTERVAL_MAX;
				// Counter restarts at zero on the advance edge, so add that edge back
				else
					step_interval_reg <= (idle_count_reg + 20'h00001) >> shift_eff;
			end
			else if (standstill || idle_count_reg == INTERVAL_MAX)
				step_interval_reg <= INTERVAL_MAX;
		end
	end

	// Quiet mode selection with hysteresis
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			quiet_mode_active <= 1'b0;
		else if (!quiet_mode_enable || quiet_threshold_reg == 20'h00000)
			quiet_mode_active <= 1'b0;
		else if (step_interval_reg >= quiet_threshold_reg)
			quiet_mode_active <= 1'b1;
		else if (step_interval_reg < lower_compare)
			quiet_mode_active <= 1'b0;
	end

	// Power tick every 2^18 clocks
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			prescale_reg <= 20'h00000;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= (prescale_reg == TICK_LAST);
			prescale_reg <= (prescale_reg == TICK_LAST) ? 20'h00000 : prescale_reg + 20'h00001;
		end
	end

	// Standstill power-down sequence
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			power_state_reg <= PD_RUN;
			delay_count_reg <= 8'h00;
			ramp_count_reg <= 4'h0;
			current_scale <= 5'h00;
		end
		else if (advance)
		begin
			power_state_reg <= PD_RUN;
			delay_count_reg <= 8'h00;
			ramp_count_reg <= 4'h0;
			current_scale <= run_current;
		end
		else
		begin
			case (power_state_reg)
				PD_RUN:
				begin
					current_scale <= run_current;
					delay_count_reg <= 8'h00;
					if (standstill)
						power_state_reg <= PD_DELAY;
				end
				PD_DELAY:
				begin
					if (delay_count_reg >= power_down_delay_reg)
						power_state_reg <= PD_RAMP;
					else if (tick_reg)
						delay_count_reg <= delay_count_reg + 8'h01;
				end
				PD_RAMP:
				begin
					if (current_ramp_down_step_delay == 4'h0)
					begin
						current_scale <= hold_current;
						power_state_reg <= PD_HOLD;
					end
					else if (current_scale <= hold_current)
					begin
						current_scale <= hold_current;
						power_state_reg <= PD_HOLD;
					end
					else if (tick_reg)
					begin
						if (ramp_count_reg + 4'h1 >= current_ramp_down_step_delay)
						begin
							ramp_count_reg <= 4'h0;
							current_scale <= current_scale - 5'h01;
						end
						else
							ramp_count_reg <= ramp_count_reg + 4'h1;
					end
				end
				PD_HOLD: current_scale <= hold_current;
				default: power_state_reg <= PD_RUN;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_pos_read;
		reg_read && reg_addr == ADDR_MICROSTEP_POSITION;
	endsequence
	sequence s_pos_answer;
		##1 reg_rdata == {22'h000000, $past(microstep_position_reg)};
	endsequence
	sequence s_delay_done;
		power_state_reg == PD_DELAY && delay_count_reg >= power_down_delay_reg && !advance;
	endsequence

	a_still_interval_max: assert property (standstill |-> ##1 step_interval_reg == INTERVAL_MAX)
		else $error("interval not saturated at standstill");
	a_index_from_gen: assert property (gen_step |=> index_pulse)
		else $error("generated step missing on index");
	a_no_index_idle: assert property (!velocity_mode [*2] |-> !index_pulse)
		else $error("index pulse without velocity mode");
	a_step_advance_pos: assert property (!velocity_mode && step_edge && !dir_s2_reg
		|=> microstep_position_reg == $past(microstep_position_reg) + $past(step_increment))
		else $error("step input did not advance position");
	a_phase_b_offset: assert property (1'b1 |=>
		phase_b_current == table_value($past(microstep_position_reg) + PHASE_OFFSET))
		else $error("phase b not offset by 256");
	a_quiet_disabled: assert property (quiet_threshold_reg == 20'h00000 |=> !quiet_mode_active)
		else $error("quiet mode active with zero threshold");
	a_quiet_enter: assert property (quiet_mode_enable && quiet_threshold_reg != 20'h00000
		&& step_interval_reg >= quiet_threshold_reg |=> quiet_mode_active)
		else $error("quiet mode not entered");
	a_quiet_hold_band: assert property (quiet_mode_active && quiet_mode_enable
		&& quiet_threshold_reg != 20'h00000
		&& step_interval_reg >= lower_compare |=> quiet_mode_active)
		else $error("quiet mode left inside hysteresis band");
	a_ro_write_ignored: assert property (reg_write && reg_addr == ADDR_MICROSTEP_POSITION
		&& !advance |=> microstep_position_reg == $past(microstep_position_reg))
		else $error("write changed microstep position");
	a_pos_readback: assert property (s_pos_read |-> s_pos_answer)
		else $error("position readback mismatch");
	a_delay_to_ramp: assert property (s_delay_done |=> power_state_reg == PD_RAMP)
		else $error("power-down delay did not expire");
	a_instant_down: assert property (power_state_reg == PD_RAMP && current_ramp_down_step_delay == 4'h0
		&& !advance |=> current_scale == $past(hold_current))
		else $error("instant power-down failed");
	a_run_on_move: assert property (advance |=> current_scale == $past(run_current)
		&& power_state_reg == PD_RUN)
		else $error("current not restored on motion");
	a_vel_dir: assert property (velocity_mode && gen_step && vel_negative
		|=> microstep_position_reg == $past(microstep_position_reg) - 10'h001)
		else $error("negative velocity did not step backward");
endmodule
`default_nettype wire

// file: tb/step_host.sv
// Host model: drives the step/dir pins and the register strobe port.
// Assumes callers sit at or just after a rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module step_host
(
	// Clock
	input wire logic clk_sys,
	// Pins
	output logic step_pin,
	output logic dir_pin,
	// Register port
	output logic reg_write,
	output logic reg_read,
	output logic [6:0] reg_addr,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata
);
	initial
	begin
		step_pin = 1'b0;
		dir_pin = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 32'h0;
	end
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		// Offset tuning needs a delay of two or more
		reg_wdata <= (a == 7'h11 && d < 32'h2) ? 32'h2 : d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		// Idle bus shows other values so a stale address cannot pass
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
	task automatic steps(input int n, input int per, input logic d);
		@(posedge clk_sys);
		dir_pin <= d;
		repeat (n)
		begin
			step_pin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			step_pin <= 1'b0;
			repeat (per - 4) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// file: tb/stepper_velocity_timing_regs_tb_top.sv
// Bench top: host model plus integer model of position, interval and quiet mode.
// Runs the block with 16-clock ticks and 64-clock standstill detection.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("unexpected at %0t: %h vs %h", $time, (g), (e)); \
		end \
	end
module stepper_velocity_timing_regs_tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic step_pin, dir_pin, reg_write, reg_read, quiet_mode_enable;
	logic [6:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, driver_flags, rd;
	logic [4:0] run_current, hold_current, current_scale;
	logic [3:0] ramp;
	logic [7:0] ofs, grad;
	logic [16:0] amp;
	logic index_pulse, motor_dir, standstill, quiet_mode_active;
	logic [8:0] pa, pb, saved;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int idx = 0;
	int pos = 0;
	int iv, thr, qm, n, c1, c2, c3;
	int c1_tab [4] = '{50, 37, 30, 38};
	always #20 clk_sys = ~clk_sys;
	// Counting on the falling edge keeps clear of the design's updates
	always @(negedge clk_sys)
	begin
		cycles++;
		if (index_pulse === 1'b1)
			idx++;
		if (cycles == 20000)
		begin
			err_count++;
			finish_test();
		end
	end
	step_host host (.clk_sys(clk_sys), .step_pin(step_pin), .dir_pin(dir_pin),
		.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	stepper_velocity_timing_regs #(.TICK_CYCLES(16), .STILL_CYCLES(64)) dut (
		.clk_sys(clk_sys), .reset(reset), .step_pin(step_pin), .dir_pin(dir_pin),
		.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.quiet_mode_enable(quiet_mode_enable), .run_current(run_current),
		.hold_current(hold_current), .current_ramp_down_step_delay(ramp),
		.auto_offset_value(ofs), .auto_gradient_value(grad), .pwm_amplitude(amp),
		.driver_flags(driver_flags), .index_pulse(index_pulse), .motor_dir(motor_dir),
		.standstill(standstill), .quiet_mode_active(quiet_mode_active),
		.current_scale(current_scale), .phase_a_current(pa), .phase_b_current(pb));
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Reference table: parabola per half wave, peak clamped, sign from the upper half
	function automatic logic [8:0] tab_ref(input int p);
		int h;
		int m;
		h = p & 511;
		m = (h * (512 - h)) >> 8;
		if (m > 255)
			m = 255;
		return (p & 512) ? 9'(-m) : 9'(m);
	endfunction
	task automatic chk_rd(input logic [6:0] a, input logic [31:0] e);
		host.rd(a, rd);
		`CHK(rd, e)
	endtask
	task automatic run(input int k, input int per, input logic d, input int m);
		host.steps(k, per, d);
		pos = (pos + (d ? -k : k) * (1 << m)) & 1023;
		iv = per >> m;
		if (!quiet_mode_enable || thr == 0)
			qm = 0;
		else if (iv >= thr)
			qm = 1;
		else if (iv < ((thr * 15) >> 4) - 1)
			qm = 0;
	endtask
	// Counts clocks from standstill until the hold current is reached
	task automatic power_down(input int lo, input int hi);
		n = 0;
		while (standstill !== 1'b1 && n < 200)
		begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(standstill, 1'b1)
		n = 0;
		while (current_scale !== hold_current && n < 2000)
		begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask
	task automatic vel(input logic [23:0] v, output int c);
		host.rd(7'h6A, rd);
		`CHK(rd[9:0], pos[9:0])
		idx = 0;
		host.wr(7'h22, {8'h0, v});
		// Step input must be ignored meanwhile
		host.steps(4, 20, 1'b0);
		repeat (300) @(posedge clk_sys);
		host.wr(7'h22, 32'h0);
		repeat (4) @(posedge clk_sys);
		c = idx;
		pos = (pos + (v[23] ? -c : c)) & 1023;
		chk_rd(7'h6A, pos);
	endtask
	initial
	begin
		void'($urandom(32'hDC81E8CC));
		ofs <= 8'($urandom);
		grad <= 8'($urandom);
		amp <= 17'($urandom);
		driver_flags <= $urandom;
		run_current <= 5'h14;
		hold_current <= 5'h05;
		ramp <= 4'h0;
		quiet_mode_enable <= 1'b0;
		thr = 0;
		qm = 0;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		chk_rd(7'h6C, 32'h10000053);
		chk_rd(7'h70, 32'hC10D0024);
		chk_rd(7'h11, 32'h0);
		chk_rd(7'h12, 32'hFFFFF);
		host.wr(7'h6A, 32'h155);
		chk_rd(7'h6A, 32'h0);
		chk_rd(7'h05, 32'h0);
		chk_rd(7'h72, {8'h0, grad, 8'h0, ofs});
		chk_rd(7'h71, {15'h0, amp});
		chk_rd(7'h6F, driver_flags);
		run(3, 20, 1'b0, 0);
		chk_rd(7'h12, 32'd20);
		chk_rd(7'h6A, pos);
		`CHK(idx, 0)
		`CHK(current_scale, run_current)
		host.wr(7'h6C, 32'h12000053);
		run(3, 24, 1'b1, 2);
		chk_rd(7'h12, 32'd6);
		chk_rd(7'h6A, pos);
		`CHK(motor_dir, 1'b1)
		host.wr(7'h6C, 32'h10000053);
		quiet_mode_enable <= 1'b1;
		thr = 40;
		host.wr(7'h13, 32'd40);
		foreach (c1_tab[i])
		begin
			run(3, c1_tab[i], 1'b0, 0);
			chk_rd(7'h12, c1_tab[i]);
			`CHK(quiet_mode_active, qm[0])
		end
		thr = 0;
		host.wr(7'h13, 32'h0);
		run(3, 50, 1'b0, 0);
		host.rd(7'h12, rd);
		`CHK(quiet_mode_active, 1'b0)
		host.wr(7'h6C, 32'h18000053);
		host.rd(7'h6A, rd);
		saved = pb;
		run(1, 20, 1'b0, 8);
		chk_rd(7'h6B, {7'h0, tab_ref(pos), 7'h0, tab_ref(pos + 256)});
		`CHK(pa, saved)
		host.wr(7'h6C, 32'h10000053);
		power_down(300, 340);
		run(1, 20, 1'b0, 0);
		`CHK(current_scale, run_current)
		ramp <= 4'h2;
		host.wr(7'h11, 32'h1);
		power_down(490, 540);
		vel(24'h080000, c1);
		vel(24'h100000, c2);
		vel(24'hF00000, c3);
		`CHK(c1 > 4 && c2 - 2 * c1 <= 2 && 2 * c1 - c2 <= 2, 1'b1)
		`CHK(c3 > 4, 1'b1)
		finish_test();
	end
endmodule
`default_nettype wire
